/* shared/pab_pkg.sv */
// Purpose: Shared constants and carriers for the PHY auto-negotiation ability registers
// Assumes: 5-bit management register addresses, 16-bit register data
// Notes: Offsets are register indices on the management port, not byte addresses

package pab_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam int PAB_AW = 5;                                 // Management address width
	localparam int PAB_DW = 16;                                // Register data width
	localparam logic [4:0] PAB_ADVERTISE_OFS = 5'h04;          // autoneg_advertise
	localparam logic [4:0] PAB_PARTNER_OFS = 5'h05;            // partner_base_ability
	localparam logic [4:0] PAB_EXPANSION_OFS = 5'h06;          // autoneg_expansion

	// ************************************************************
	// Advertisement field layout and reset values
	// ************************************************************
	localparam int PAB_NP_BIT = 15;                            // next_page_flag
	localparam int PAB_RF_BIT = 13;                            // remote_fault_advert
	localparam int PAB_TECH_LSB = 5;                           // Technology field low bit
	localparam int PAB_TECH_W = 4;                             // Technology field width
	localparam int PAB_SEL_W = 5;                              // Selector field width
	localparam logic [4:0] PAB_SELECTOR = 5'h01;               // Fixed selector code
	localparam logic [15:0] PAB_ADVERTISE_RST = 16'h01E1;      // Advertisement after reset
	localparam logic [15:0] PAB_ADVERTISE_WMASK = 16'h21E0;    // Writable bits: RF and 8:5
	localparam logic [15:0] PAB_PARTNER_RST = 16'h0000;        // Partner page after reset
	localparam logic [15:0] PAB_EXPANSION_RST = 16'h0000;      // Expansion after reset

	// Technology bit positions inside the 4-bit field
	localparam int PAB_T_10T_HALF = 0;                         // adv_10t_half
	localparam int PAB_T_10T_FULL = 1;                         // adv_10t_full
	localparam int PAB_T_100TX_HALF = 2;                       // adv_100tx_half
	localparam int PAB_T_100TX_FULL = 3;                       // adv_100tx_full

	// ************************************************************
	// Expansion register layout
	// ************************************************************
	localparam int PAB_EXP_LP_AN_BIT = 0;                      // Partner can negotiate
	localparam int PAB_EXP_PAGE_RX_BIT = 1;                    // A base page was received
	localparam int PAB_EXP_LOC_NP_BIT = 2;                     // Local next-page capable
	localparam int PAB_EXP_LP_NP_BIT = 3;                      // Partner next-page capable

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic [PAB_AW-1:0] addr;                               // Register index
		logic [PAB_DW-1:0] wdata;                              // Write data
		logic wr;                                              // Write strobe
		logic rd;                                              // Read strobe
	} pab_bus_req_t;

	typedef struct packed {
		logic [PAB_DW-1:0] page;                               // Partner base page word
		logic page_valid;                                      // Page word is valid
		logic an_done;                                         // Negotiation finished
		logic lp_an_able;                                      // Partner negotiates
		logic lp_np_able;                                      // Partner has next pages
	} pab_link_evt_t;

endpackage

/* hw/pab_regs.sv */
// Purpose: Auto-negotiation advertisement, partner ability and expansion registers
// Assumes: Synchronous inputs on mclk; restart pulse comes from the control register
// Notes: The advertisement seen by the link is a shadow that loads only on restart
//
// Overview of operation
// - New advertisement applied only on negotiation restart
// - Bits 8:5 are writable technology abilities
// - Cleared 10BASE-T half bit blocks that mode
// - Selector bits 4:0 read-only, fixed 0x01
// - Advertisement resets to 0x01E1
// - Partner base page captured, read-only, resets zero
// - Expansion reports both ends' negotiation capabilities
//
// The plain strobed port is this design's own decision.

`timescale 1ns/100ps
`default_nettype none

module pab_regs
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire pab_pkg::pab_bus_req_t bus_req,
	input wire logic restart_negotiation,
	input wire pab_pkg::pab_link_evt_t link_evt,
	output logic [15:0] rdata,
	output logic [15:0] link_advertise,
	output logic [3:0] negotiated_mode
);
	import pab_pkg::*;

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [15:0] advert;         // Software view of the advertisement
		logic [15:0] applied;        // Copy currently offered on the link
		logic [15:0] partner;        // Captured partner base page
		logic [15:0] expansion;      // Capability report
		logic [3:0] mode;            // One-hot chosen technology
		logic [15:0] rdata;          // Read data, valid the cycle after a read
	} pab_state_t;

	pab_state_t st;                  // Registered state
	pab_state_t next_st;             // Next state

	// ************************************************************
	// Functions
	// ************************************************************
	// Highest common technology, one-hot; zero when nothing is shared
	function automatic logic [3:0] pab_resolve(input logic [3:0] common);
		logic [3:0] res;
		res = 4'h0;
		if (common[PAB_T_100TX_FULL])
		begin
			res[PAB_T_100TX_FULL] = 1'b1;
		end
		else if (common[PAB_T_100TX_HALF])
		begin
			res[PAB_T_100TX_HALF] = 1'b1;
		end
		else if (common[PAB_T_10T_FULL])
		begin
			res[PAB_T_10T_FULL] = 1'b1;
		end
		else if (common[PAB_T_10T_HALF])
		begin
			res[PAB_T_10T_HALF] = 1'b1;
		end
		return res;
	endfunction

	// Technology field of a register word
	function automatic logic [3:0] pab_tech(input logic [15:0] word);
		return word[PAB_TECH_LSB +: PAB_TECH_W];
	endfunction

	// ************************************************************
	// Next-state logic
	// ************************************************************
	// Everything holds while the clock enable is low
	always_comb
	begin
		next_st = st;
		if (ce)
		begin
			// Read data only stands for the one cycle after a read
			next_st.rdata = 16'h0000;
			if (bus_req.rd)
			begin
				unique case (bus_req.addr)
					PAB_ADVERTISE_OFS: next_st.rdata = st.advert;
					PAB_PARTNER_OFS: next_st.rdata = st.partner;
					PAB_EXPANSION_OFS: next_st.rdata = st.expansion;
					// Unmapped indices answer zero
					default: next_st.rdata = 16'h0000;
				endcase
			end
			// Only RF and the technology bits take writes; selector stays fixed
			if (bus_req.wr && (bus_req.addr == PAB_ADVERTISE_OFS))
			begin
				next_st.advert = (bus_req.wdata & PAB_ADVERTISE_WMASK) |
					(PAB_ADVERTISE_RST & ~PAB_ADVERTISE_WMASK);
			end
			// Partner and expansion registers ignore writes
			if (link_evt.page_valid)
			begin
				next_st.partner = link_evt.page;
			end
			// Restart offers the current software view and drops the old result
			if (restart_negotiation)
			begin
				next_st.applied = st.advert;
				next_st.mode = 4'h0;
			end
			else if (link_evt.an_done)
			begin
				// Only abilities both ends offer can be chosen
				next_st.mode = pab_resolve(pab_tech(st.applied) & pab_tech(st.partner));
				next_st.expansion = PAB_EXPANSION_RST;
				next_st.expansion[PAB_EXP_LP_AN_BIT] = link_evt.lp_an_able;
				next_st.expansion[PAB_EXP_PAGE_RX_BIT] = 1'b1;
				next_st.expansion[PAB_EXP_LOC_NP_BIT] = st.applied[PAB_NP_BIT];
				next_st.expansion[PAB_EXP_LP_NP_BIT] = link_evt.lp_np_able;
			end
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	// Reset loads constants only
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st.advert <= PAB_ADVERTISE_RST;
			st.applied <= PAB_ADVERTISE_RST;
			st.partner <= PAB_PARTNER_RST;
			st.expansion <= PAB_EXPANSION_RST;
			st.mode <= 4'h0;
			st.rdata <= 16'h0000;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	// All outputs are flop fields, no logic after them
	assign rdata = st.rdata;
	assign link_advertise = st.applied;
	assign negotiated_mode = st.mode;

	// ************************************************************
	// Assertions
	// ************************************************************
	// Link copy holds between restarts, so writes do not leak early
	adv_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!(ce && restart_negotiation) |=> $stable(st.applied))
		else $error("link advertisement changed without restart");

	// Restart loads exactly the software view
	adv_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && restart_negotiation) |=> (link_advertise == $past(st.advert)))
		else $error("restart did not load advertisement");

	// Technology bits follow a write
	tech_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && bus_req.wr && bus_req.addr == PAB_ADVERTISE_OFS)
		|=> (pab_tech(st.advert) == pab_tech($past(bus_req.wdata))))
		else $error("technology field did not take write");

	// 10BASE-T half is never chosen unless offered locally
	half_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
		negotiated_mode[PAB_T_10T_HALF] |-> link_advertise[PAB_TECH_LSB + PAB_T_10T_HALF])
		else $error("10BASE-T half chosen while not advertised");

	// Selector always reads its fixed code
	sel_fixed_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && bus_req.rd && bus_req.addr == PAB_ADVERTISE_OFS)
		|=> (rdata[PAB_SEL_W-1:0] == PAB_SELECTOR))
		else $error("selector field not 0x01");

	// Advertisement leaves reset with its documented word
	adv_reset_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(rst_n) |-> (st.advert == 16'h01E1 && link_advertise == 16'h01E1))
		else $error("advertisement reset value wrong");

	// Partner register captures the page a cycle later
	partner_cap_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && link_evt.page_valid) |=> (st.partner == $past(link_evt.page)))
		else $error("partner page not captured");

	// Writes do not reach the partner register
	partner_ro_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && bus_req.wr && !link_evt.page_valid) |=> $stable(st.partner))
		else $error("partner register changed by write");

	// Expansion reports the partner's abilities and the received page after completion
	exp_report_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && link_evt.an_done && !restart_negotiation)
		|=> (st.expansion[PAB_EXP_LP_AN_BIT] == $past(link_evt.lp_an_able)
			&& st.expansion[PAB_EXP_LP_NP_BIT] == $past(link_evt.lp_np_able)
			&& st.expansion[PAB_EXP_PAGE_RX_BIT]))
		else $error("expansion register not updated");

	// Chosen mode is one both ends offer
	mode_common_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && link_evt.an_done && !restart_negotiation)
		|=> ((negotiated_mode & ~(pab_tech(link_advertise) & pab_tech(st.partner))) == 4'h0))
		else $error("mode chosen outside common abilities");

	// Clock enable low freezes every state field, read data included
	ce_freeze_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!ce |=> $stable(st))
		else $error("state moved while clock enable low");

	// Read data fall back to zero when no read was taken
	rdata_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && !bus_req.rd) |=> (rdata == 16'h0000))
		else $error("read data stood without a read");

	// Advertisement read returns the software view
	adv_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && bus_req.rd && bus_req.addr == PAB_ADVERTISE_OFS)
		|=> (rdata == $past(st.advert)))
		else $error("advertisement read wrong");

	// Partner read returns the captured page
	partner_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && bus_req.rd && bus_req.addr == PAB_PARTNER_OFS)
		|=> (rdata == $past(st.partner)))
		else $error("partner read wrong");

	// Expansion read returns the capability report
	exp_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && bus_req.rd && bus_req.addr == PAB_EXPANSION_OFS)
		|=> (rdata == $past(st.expansion)))
		else $error("expansion read wrong");

	// Unmapped indices read as zero
	unmapped_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && bus_req.rd && bus_req.addr != PAB_ADVERTISE_OFS
			&& bus_req.addr != PAB_PARTNER_OFS && bus_req.addr != PAB_EXPANSION_OFS)
		|=> (rdata == 16'h0000))
		else $error("unmapped read not zero");

	// Writes elsewhere leave the advertisement alone
	adv_other_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && bus_req.wr && bus_req.addr != PAB_ADVERTISE_OFS) |=> $stable(st.advert))
		else $error("advertisement changed by foreign write");

	// Reserved and next-page bits stay zero, selector stays fixed
	adv_resv_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(st.advert[15:14] == 2'h0 && st.advert[12:9] == 4'h0
			&& st.advert[PAB_SEL_W-1:0] == PAB_SELECTOR))
		else $error("advertisement fixed bits disturbed");

	// Link copy carries the selector code as well
	link_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
		link_advertise[PAB_SEL_W-1:0] == PAB_SELECTOR)
		else $error("link selector not fixed");

	// Restart drops the previous result
	restart_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(ce && restart_negotiation) |=> (negotiated_mode == 4'h0))
		else $error("mode kept across restart");

	// Result holds until the next restart or completion
	mode_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(!restart_negotiation && !link_evt.an_done) |=> $stable(negotiated_mode))
		else $error("mode changed without event");

	// At most one technology is chosen
	mode_onehot_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$onehot0(negotiated_mode))
		else $error("more than one mode chosen");

	// 100BASE-TX full needs its advertised bit
	full100_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
		negotiated_mode[PAB_T_100TX_FULL] |-> link_advertise[PAB_TECH_LSB + PAB_T_100TX_FULL])
		else $error("100TX full chosen while not advertised");

	// 100BASE-TX half needs its advertised bit
	half100_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
		negotiated_mode[PAB_T_100TX_HALF] |-> link_advertise[PAB_TECH_LSB + PAB_T_100TX_HALF])
		else $error("100TX half chosen while not advertised");

	// 10BASE-T full needs its advertised bit
	full10_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
		negotiated_mode[PAB_T_10T_FULL] |-> link_advertise[PAB_TECH_LSB + PAB_T_10T_FULL])
		else $error("10T full chosen while not advertised");

	// Expansion only moves on completion
	exp_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!link_evt.an_done |=> $stable(st.expansion))
		else $error("expansion changed without completion");

	// No next pages are offered locally, so the report bit stays low
	loc_np_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!st.expansion[PAB_EXP_LOC_NP_BIT])
		else $error("local next page reported");

	// Unused expansion bits read zero
	exp_resv_a: assert property (@(posedge mclk) disable iff (!rst_n)
		st.expansion[15:4] == 12'h000)
		else $error("expansion reserved bits set");

endmodule

`default_nettype wire

/* tb/pab_partner.sv */
// Purpose: Remote link partner that sends one base page, then ends negotiation
// Assumes: go is a one-cycle request from the bench
// Notes: Outside its valid cycle the page word toggles, so stale data never matches
`timescale 1ns/100ps
`default_nettype none
module pab_partner
	import pab_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic [15:0] page_in,
	input wire logic np_in,
	output pab_link_evt_t link_evt
);
	// ************************************************************
	// Page then done, one cycle apart
	// ************************************************************
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			link_evt <= '0;
		else
		begin
			link_evt.page_valid <= go;
			// Released word shows its inverse, not the last value
			link_evt.page <= go ? page_in : ~link_evt.page;
			// Done follows the page by one cycle
			link_evt.an_done <= link_evt.page_valid;
			link_evt.lp_an_able <= 1'b1;
			// Held steady from the page until done samples it
			link_evt.lp_np_able <= go ? np_in : link_evt.lp_np_able;
		end
	end
endmodule
`default_nettype wire

/* tb/pab_regs_tb_top.sv */
// Purpose: Self-checking bench for the auto-negotiation ability registers
// Assumes: Clock enable held high except in the final ce test; one partner page per negotiation
// Notes: Random words come from a bench LFSR seeded with 71
`timescale 1ns/100ps
`default_nettype none
module pab_regs_tb_top;
	import pab_pkg::*;
	logic mclk;
	logic rst_n;
	logic ce;
	logic restart_negotiation;
	logic go;
	logic np;
	logic [15:0] page;
	pab_bus_req_t bus_req;
	pab_link_evt_t link_evt;
	logic [15:0] rdata;
	logic [15:0] link_advertise;
	logic [3:0] negotiated_mode;
	logic [15:0] lfsr;
	logic [15:0] adv;
	logic [15:0] w;
	int n_errors;
	int n_tests;
	pab_regs dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .bus_req(bus_req),
		.restart_negotiation(restart_negotiation), .link_evt(link_evt), .rdata(rdata),
		.link_advertise(link_advertise), .negotiated_mode(negotiated_mode));
	pab_partner partner (.mclk(mclk), .rst_n(rst_n), .go(go), .page_in(page), .np_in(np),
		.link_evt(link_evt));
	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [15:0] next_rnd(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	// Highest common ability wins; none gives zero
	function automatic logic [3:0] exp_mode(input logic [3:0] c);
		if (c[3]) return 4'h8;
		if (c[2]) return 4'h4;
		if (c[1]) return 4'h2;
		return c[0] ? 4'h1 : 4'h0;
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic bus_wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge mclk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus_req.wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic bus_rd(input logic [4:0] a);
		@(posedge mclk);
		bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus_req.rd <= 1'b0;
		#1;
	endtask
	task automatic print_verdict;
		$display("checks=%0d mismatches=%0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ************************************************************
	// Clock and watchdog
	// ************************************************************
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial
	begin
		#20000;
		n_errors++;
		print_verdict;
	end
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		{rst_n, restart_negotiation, go, np, page, bus_req} = '0;
		ce = 1'b1;
		lfsr = 16'h0047;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		#1;
		check(link_advertise, PAB_ADVERTISE_RST);
		check({12'h000, negotiated_mode}, 16'h0000);
		bus_rd(PAB_ADVERTISE_OFS); check(rdata, 16'h01E1);
		bus_rd(PAB_PARTNER_OFS); check(rdata, 16'h0000);
		bus_rd(PAB_EXPANSION_OFS); check(rdata, 16'h0000);
		for (int i = 0; i < 12; i++)
		begin
			lfsr = next_rnd(lfsr);
			w = lfsr;
			// First five passes walk the ability field down to empty
			if (i < 5) w[8:5] = 4'hF >> i;
			adv = link_advertise;
			bus_wr(PAB_ADVERTISE_OFS, w);
			bus_rd(PAB_ADVERTISE_OFS); check(rdata, (w & 16'h21E0) | 16'h0001);
			check(link_advertise, adv);
			@(posedge mclk) restart_negotiation <= 1'b1;
			@(posedge mclk) restart_negotiation <= 1'b0;
			#1;
			check(link_advertise, (w & 16'h21E0) | 16'h0001);
			check({12'h000, negotiated_mode}, 16'h0000);
			lfsr = next_rnd(lfsr);
			page = lfsr;
			if (i < 5) page[8:5] = 4'hF;
			np = lfsr[0];
			@(posedge mclk) go <= 1'b1;
			@(posedge mclk) go <= 1'b0;
			repeat (2) @(posedge mclk);
			#1;
			check({12'h000, negotiated_mode}, {12'h000, exp_mode(w[8:5] & page[8:5])});
			bus_wr(PAB_PARTNER_OFS, ~page);
			bus_wr(PAB_EXPANSION_OFS, 16'hFFFF);
			bus_rd(PAB_PARTNER_OFS); check(rdata, page);
			bus_rd(PAB_EXPANSION_OFS); check(rdata, {12'h000, np, 3'h3});
			bus_rd(5'h07 + {1'b0, lfsr[4:1]}); check(rdata, 16'h0000);
			$display("test %0d done", i);
		end
		// A write taken while the clock enable is low must be lost
		@(posedge mclk) ce <= 1'b0;
		bus_wr(PAB_ADVERTISE_OFS, 16'h0000);
		@(posedge mclk) ce <= 1'b1;
		bus_rd(PAB_ADVERTISE_OFS); check(rdata, (w & 16'h21E0) | 16'h0001);
		$display("test ce done");
		print_verdict;
	end
endmodule
`default_nettype wire
